// ### logic/cife_top.v
// configuration front end: init pin handling, mode sampling, width detect, sync
`timescale 1ns/1ps
`default_nettype none

`include "cife_defs.vh"

// Function
// - external low on init pin during initialization postpones configuration.
// - after init pin rose, later external lows are ignored.
// - low program input resets all but the apb side, control register and pin synchroniser asynchronously and holds it.
// - after mode sampling init pin drives low open-drain on crc errors.
// - status bit shows whether the configuration memory clear has finished.
// - three status bits return live mode pin levels when read.
// - three status bits hold flash select pins captured at init rise.
// - parallel modes detect bus width before the sync word search.
// - serial, serial flash and scan modes skip width detection.
// - sync word aa995566 marks that configuration data follows.
// - on sync word match, word boundaries align to it.
// - data before sync is discarded except the width pattern.
// - sync flag visible only during abort, in serial and parallel modes alike.
// - detected width reported as two-bit code x1/x8/x16/x32.
// - init pin driven low while initializing; wait while held externally.
// - mode pins sampled at init rise, then data on clock rises.
// - configuration memory cleared twice after program release.
module cife_top #(
  parameter CLEAR_CYCLES = `CIFE_CLEAR_CYCLES
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // configuration pins
  input  wire        programN,
  input  wire        initPinIn,
  output wire        initPinOut,
  output reg         initPinOe,
  input  wire [2:0]  modeSelPins,
  input  wire [2:0]  flashSelectPins,
  input  wire        configClock,
  input  wire [31:0] configData,
  // core side
  input  wire        cfgDone,
  input  wire        cfgCrcError,
  input  wire        readbackCrcError,
  input  wire        abortActive,
  output reg         wordSyncFlag,
  output wire        memClearActive,
  output wire [31:0] alignedWord,
  output wire        alignedWordValid
);

  // one-hot configuration states
  localparam [4:0] ST_CLEAR   = 5'h01;
  localparam [4:0] ST_RELEASE = 5'h02;
  localparam [4:0] ST_WIDTH   = 5'h04;
  localparam [4:0] ST_HUNT    = 5'h08;
  localparam [4:0] ST_SYNCED  = 5'h10;

  reg  [4:0]  state_r;
  reg  [4:0]  state_nxt;
  reg  [15:0] clrCnt_r;
  reg         clrPass_r;
  reg  [2:0]  modeSampled_r;
  reg  [2:0]  capturedFlashSelect_r;
  reg  [1:0]  detectedBusWidth_r;
  reg         markSeen_r;
  reg         crcErr_r;
  reg         cfgClkLast_r;
  reg  [3:0]  ctrl_r;
  reg  [31:0] lastWord_r;
  reg  [1:0]  rstSync_r;
  wire        rstN;
  wire        chipRstRawN;
  wire        initSync;
  wire        cfgClkSync;
  wire [2:0]  modeSync;
  wire [2:0]  flashSelSync;
  wire [31:0] dataSync;
  wire        cfgClkRise;
  wire        serialMode;
  wire        clrLast;
  wire        synced;
  wire [1:0]  widthReport;
  wire [31:0] statusWord;
  wire        apbAccess;
  wire        regHit;

  // program pin and core reset both clear the configuration logic; release is synchronous
  assign chipRstRawN = arst_n & programN;

  always @(posedge core_clk or negedge chipRstRawN) begin
    if (!chipRstRawN) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  assign rstN = rstSync_r[1];

  // every configuration pin except programN is filtered the same way,
  // so data and its clock stay aligned through the synchroniser
  cife_pin_sync #(
    .WIDTH (40)
  ) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    ({initPinIn, configClock, modeSelPins, flashSelectPins, configData}),
    .pinOut   ({initSync, cfgClkSync, modeSync, flashSelSync, dataSync})
  );

  // rising edge of the configuration clock as seen by core_clk
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      cfgClkLast_r <= 1'b0;
    end else begin
      cfgClkLast_r <= cfgClkSync;
    end
  end

  assign cfgClkRise = cfgClkSync & ~cfgClkLast_r;

  // serial-style ports ignore the width pattern
  function isSerial;
    input [2:0] m;
    begin
      case (m)
        `CIFE_M_MSERIAL,
        `CIFE_M_SPI,
        `CIFE_M_JTAG,
        `CIFE_M_SSERIAL: isSerial = 1'b1;
        default:         isSerial = 1'b0;
      endcase
    end
  endfunction

  assign serialMode = isSerial(modeSampled_r);
  assign clrLast    = (clrCnt_r == CLEAR_CYCLES[15:0] - 16'h0001);

  // next state of the configuration sequence
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_CLEAR: begin
        if (clrLast && clrPass_r)
          state_nxt = ST_RELEASE;
      end
      ST_RELEASE: begin
        // pin still held low by the outside: keep waiting
        if (initSync) begin
          if (isSerial(modeSync))
            state_nxt = ST_HUNT;
          else
            state_nxt = ST_WIDTH;
        end
      end
      ST_WIDTH: begin
        if (cfgClkRise && markSeen_r &&
            (dataSync == `CIFE_WD_X32 || dataSync[15:0] == `CIFE_WD_X16 ||
             dataSync[7:0] == `CIFE_WD_X8))
          state_nxt = ST_HUNT;
      end
      ST_HUNT: begin
        if (synced)
          state_nxt = ST_SYNCED;
      end
      ST_SYNCED: begin
        state_nxt = ST_SYNCED;
      end
      default: begin
        state_nxt = ST_CLEAR;
      end
    endcase
  end

  // state register, clear passes and init-rise captures
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_r               <= ST_CLEAR;
      clrCnt_r              <= 16'h0000;
      clrPass_r             <= 1'b0;
      modeSampled_r         <= 3'h0;
      capturedFlashSelect_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_CLEAR) begin
        if (clrLast) begin
          clrCnt_r  <= 16'h0000;
          clrPass_r <= 1'b1;
        end else begin
          clrCnt_r <= clrCnt_r + 16'h0001;
        end
      end
      // only sampled on the one rise; later lows are never looked at
      if (state_r == ST_RELEASE && initSync) begin
        modeSampled_r         <= modeSync;
        capturedFlashSelect_r <= flashSelSync;
      end
    end
  end

  assign memClearActive = (state_r == ST_CLEAR);

  // width pattern: marker byte first, then the width word; all else dropped
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      markSeen_r         <= 1'b0;
      detectedBusWidth_r <= `CIFE_W_X1;
    end else if (state_r == ST_WIDTH && cfgClkRise && !serialMode) begin
      if (!markSeen_r) begin
        markSeen_r <= (dataSync[7:0] == `CIFE_WD_MARK);
      end else if (dataSync == `CIFE_WD_X32) begin
        detectedBusWidth_r <= `CIFE_W_X32;
      end else if (dataSync[15:0] == `CIFE_WD_X16) begin
        detectedBusWidth_r <= `CIFE_W_X16;
      end else if (dataSync[7:0] == `CIFE_WD_X8) begin
        detectedBusWidth_r <= `CIFE_W_X8;
      end
    end
  end

  // search and alignment run only once the width is known
  cife_sync_hunt u_sync_hunt (
    .core_clk  (core_clk),
    .rstN      (rstN),
    .huntEn    (state_r == ST_HUNT || state_r == ST_SYNCED),
    .sampleStb (cfgClkRise),
    .widthCode (detectedBusWidth_r),
    .dataIn    (dataSync),
    .matched   (synced),
    .wordOut   (alignedWord),
    .wordValid (alignedWordValid)
  );

  // crc error flag; errors during clear and release are ignored, cleared only by chip reset
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      crcErr_r <= 1'b0;
    end else if (!(state_r == ST_CLEAR || state_r == ST_RELEASE)) begin
      if (cfgCrcError || (readbackCrcError && ctrl_r[`CIFE_CT_RB_CRC_EN]))
        crcErr_r <= 1'b1;
    end
  end

  // open drain: output level is always low, the enable does the work
  assign initPinOut = 1'b0;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      initPinOe <= 1'b1;
    end else begin
      initPinOe <= (state_nxt == ST_CLEAR) | crcErr_r;
    end
  end

  // sync flag leaves the block only while an abort is under way
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      wordSyncFlag <= 1'b0;
    end else begin
      wordSyncFlag <= abortActive & synced;
    end
  end

  // after done the internal port width replaces the detected one
  assign widthReport = (ctrl_r[`CIFE_CT_IPORT_EN] && cfgDone) ?
                       ctrl_r[`CIFE_CT_IPORT_W_LSB+1:`CIFE_CT_IPORT_W_LSB] :
                       detectedBusWidth_r;

  assign statusWord = {21'h000000,
                       (state_r == ST_SYNCED),
                       crcErr_r,
                       widthReport,
                       capturedFlashSelect_r,
                       modeSync,
                       ~(state_r == ST_CLEAR)};

  // apb: one wait state so read data comes from a flop
  assign apbAccess = psel & penable;
  assign regHit    = (paddr == `CIFE_REG_STATUS) || (paddr == `CIFE_REG_CTRL) ||
                     (paddr == `CIFE_REG_WORD);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess & ~pready;
      pslverr <= apbAccess & ~pready & ~regHit;
      if (apbAccess && !pready && !pwrite) begin
        case (paddr)
          `CIFE_REG_STATUS: prdata <= statusWord;
          `CIFE_REG_CTRL:   prdata <= {28'h0000000, ctrl_r};
          `CIFE_REG_WORD:   prdata <= lastWord_r;
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // control register; write lands on the completing edge only
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CIFE_CTRL_RESET;
    end else if (apbAccess && pready && pwrite && paddr == `CIFE_REG_CTRL) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  // last aligned word, kept for software inspection
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lastWord_r <= 32'h00000000;
    end else if (alignedWordValid) begin
      lastWord_r <= alignedWord;
    end
  end

endmodule

`default_nettype wire

// ### logic/cife_defs.vh
// constants shared by the configuration init / sync front end
`ifndef CIFE_DEFS_VH
`define CIFE_DEFS_VH

// register byte offsets on the apb side
`define CIFE_REG_STATUS      8'h00
`define CIFE_REG_CTRL        8'h04
`define CIFE_REG_WORD        8'h08

// status register field positions
`define CIFE_ST_INIT_DONE    0
`define CIFE_ST_MODE_LSB     1
`define CIFE_ST_FLSEL_LSB    4
`define CIFE_ST_WIDTH_LSB    7
`define CIFE_ST_CRC_ERR      9
`define CIFE_ST_SYNCED_SEEN  10

// control register field positions and reset value
`define CIFE_CT_IPORT_EN     0
`define CIFE_CT_IPORT_W_LSB  1
`define CIFE_CT_RB_CRC_EN    3
`define CIFE_CTRL_RESET      4'h0

// detected bus width codes
`define CIFE_W_X1            2'h0
`define CIFE_W_X8            2'h1
`define CIFE_W_X16           2'h2
`define CIFE_W_X32           2'h3

// synchronisation word, in stream bit order
`define CIFE_SYNC_WORD       32'haa995566

// bus width detection pattern: marker byte, then width word
`define CIFE_WD_MARK         8'hbb
`define CIFE_WD_X8           8'h11
`define CIFE_WD_X16          16'h1122
`define CIFE_WD_X32          32'h11220044

// mode pin codes that select a serial-style port
`define CIFE_M_MSERIAL       3'h0
`define CIFE_M_SPI           3'h1
`define CIFE_M_JTAG          3'h5
`define CIFE_M_SSERIAL       3'h7

// default length of one configuration memory clear pass, in cycles
`define CIFE_CLEAR_CYCLES    64

`endif

// ### logic/cife_pin_sync.v
// three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module cife_pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             arst_n,
  // pins from outside the clock domain
  input  wire [WIDTH-1:0] pinIn,
  // filtered levels
  output reg  [WIDTH-1:0] pinOut
);

  reg  [WIDTH-1:0] stage1_r;
  reg  [WIDTH-1:0] stage2_r;
  reg  [WIDTH-1:0] stage3_r;
  wire [WIDTH-1:0] agree;

  // stage1 feeds stage2 only; the filter looks at stages two and three
  assign agree = ~(stage2_r ^ stage3_r);

  // shift chain plus agreement filter, bit by bit
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
      pinOut   <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      pinOut   <= (agree & stage3_r) | (~agree & pinOut);
    end
  end

endmodule

`default_nettype wire

// ### logic/cife_sync_hunt.v
// sync word search and word alignment on the configuration data stream
`timescale 1ns/1ps
`default_nettype none

`include "cife_defs.vh"

module cife_sync_hunt (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstN,
  // stream input
  input  wire        huntEn,
  input  wire        sampleStb,
  input  wire [1:0]  widthCode,
  input  wire [31:0] dataIn,
  // results
  output reg         matched,
  output reg  [31:0] wordOut,
  output reg         wordValid
);

  reg  [31:0] shift_r;
  reg  [5:0]  bitCnt_r;
  wire [31:0] shiftNxt;
  wire [5:0]  cntNxt;

  // bytes on the parallel pins arrive with their bits reversed
  function [7:0] swap8;
    input [7:0] b;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        swap8[i] = b[7-i];
    end
  endfunction

  function [5:0] stepBits;
    input [1:0] w;
    begin
      case (w)
        `CIFE_W_X8:  stepBits = 6'h08;
        `CIFE_W_X16: stepBits = 6'h10;
        `CIFE_W_X32: stepBits = 6'h20;
        default:     stepBits = 6'h01;
      endcase
    end
  endfunction

  function [31:0] shiftIn;
    input [31:0] sh;
    input [1:0]  w;
    input [31:0] d;
    begin
      case (w)
        `CIFE_W_X8:  shiftIn = {sh[23:0], swap8(d[7:0])};
        `CIFE_W_X16: shiftIn = {sh[15:0], swap8(d[15:8]), swap8(d[7:0])};
        `CIFE_W_X32: shiftIn = {swap8(d[31:24]), swap8(d[23:16]),
                                swap8(d[15:8]), swap8(d[7:0])};
        default:     shiftIn = {sh[30:0], d[0]};
      endcase
    end
  endfunction

  assign shiftNxt = shiftIn(shift_r, widthCode, dataIn);
  assign cntNxt   = bitCnt_r + stepBits(widthCode);

  // compare at every step until the match, then cut aligned words
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      shift_r   <= 32'h00000000;
      bitCnt_r  <= 6'h00;
      matched   <= 1'b0;
      wordOut   <= 32'h00000000;
      wordValid <= 1'b0;
    end else begin
      wordValid <= 1'b0;
      if (huntEn && sampleStb) begin
        shift_r <= shiftNxt;
        if (!matched) begin
          if (shiftNxt == `CIFE_SYNC_WORD) begin
            matched  <= 1'b1;
            bitCnt_r <= 6'h00;
          end
        end else if (cntNxt == 6'h20) begin
          wordOut   <= shiftNxt;
          wordValid <= 1'b1;
          bitCnt_r  <= 6'h00;
        end else begin
          bitCnt_r <= cntNxt;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### verification/cife_top_asserts.sv
// concurrent checks on the front end ports
`timescale 1ns/1ps
`default_nettype none
module cife_top_asserts #(
  parameter CLEAR_CYCLES = 64
) (
  // clock and resets
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        programN,
  // apb handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and core side
  input wire logic        initPinOut,
  input wire logic        initPinOe,
  input wire logic        cfgCrcError,
  input wire logic        abortActive,
  input wire logic        wordSyncFlag,
  input wire logic        memClearActive,
  input wire logic [31:0] alignedWord,
  input wire logic        alignedWordValid
);
  logic [15:0] clrCnt_r;
  // clear length; restarts on program low so a long hold cannot pad it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) clrCnt_r <= 16'h0000;
    else if (!programN || !memClearActive) clrCnt_r <= 16'h0000;
    else clrCnt_r <= clrCnt_r + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n || !programN);
  a_apb_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_oe_prog: assert property (@(posedge core_clk) disable iff (!arst_n) !programN |-> initPinOe)
    else $error("pin not driven in program reset");
  a_drive_low: assert property (initPinOe |-> !initPinOut)
    else $error("open drain drives high");
  a_clear_drives: assert property (memClearActive |-> initPinOe)
    else $error("pin released during clear");
  a_clear_len: assert property ($fell(memClearActive) |-> clrCnt_r >= 2 * CLEAR_CYCLES)
    else $error("clear too short");
  a_crc_raise: assert property (cfgCrcError && !memClearActive |-> ##[1:4] initPinOe)
    else $error("crc error not flagged");
  a_crc_sticky: assert property (initPinOe && !memClearActive && $past(initPinOe)
    && !$past(memClearActive) |=> initPinOe)
    else $error("crc flag dropped");
  a_flag_abort: assert property (wordSyncFlag |-> $past(abortActive))
    else $error("sync flag outside abort");
  a_clear_quiet: assert property (memClearActive |-> !alignedWordValid)
    else $error("word during clear");
  a_word_pulse: assert property (alignedWordValid |=> !alignedWordValid)
    else $error("word valid too long");
  a_word_hold: assert property (!alignedWordValid |-> $stable(alignedWord))
    else $error("word changed without valid");
  c_word: cover property (alignedWordValid);
  c_flag: cover property (wordSyncFlag);
  c_release: cover property ($fell(initPinOe));
  c_err: cover property (pslverr);
endmodule
bind cife_top cife_top_asserts #(.CLEAR_CYCLES(CLEAR_CYCLES)) cife_top_asserts_inst (
  .core_clk(core_clk), .arst_n(arst_n), .programN(programN), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .initPinOut(initPinOut),
  .initPinOe(initPinOe), .cfgCrcError(cfgCrcError), .abortActive(abortActive),
  .wordSyncFlag(wordSyncFlag), .memClearActive(memClearActive),
  .alignedWord(alignedWord), .alignedWordValid(alignedWordValid)
);
`default_nettype wire

// ### verification/cife_cfg_src.sv
// behavioural configuration master on the data pins and init wire
`timescale 1ns/1ps
`default_nettype none
module cife_cfg_src (
  // init wire
  input  wire logic        initPinOut,
  input  wire logic        initPinOe,
  input  wire logic        holdLow,
  output wire logic        initPinIn,
  // data pins
  output var  logic        configClock,
  output var  logic [31:0] configData
);
  // external pull-up, low if either party pulls
  assign initPinIn = !(initPinOe && !initPinOut) && !holdLow;
  initial begin
    configClock = 1'b0;
    configData = 32'h0;
  end
  // one 160 ns beat; the 5 ns offsets keep every pin edge off the core clock edges
  task automatic send(input logic [31:0] d);
    #5 configData = d;
    #80 configClock = 1'b1;
    #70 configClock = 1'b0;
    #5;
  endtask
  // clock stands still between frames; data must not look valid
  task automatic park();
    #5 configData = ~configData;
  endtask
endmodule
`default_nettype wire

// ### verification/cife_top_test.sv
// self-checking bench for the configuration front end
`timescale 1ns/1ps
`default_nettype none
`include "cife_defs.vh"
module cife_top_test;
  localparam CLR = 4;
  localparam logic [2:0] MODES [4] = '{3'h2, 3'h6, 3'h3, 3'h1};
  localparam int WCS [4] = '{1, 2, 3, 0};
  // bench-driven inputs
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        programN = 1'b0;
  logic        holdLow = 1'b1;
  logic [2:0]  modeSelPins = 3'h0;
  logic [2:0]  flashSelectPins = 3'h0;
  logic        cfgDone = 1'b0;
  logic        cfgCrcError = 1'b0;
  logic        readbackCrcError = 1'b0;
  logic        abortActive = 1'b0;
  // design and partner outputs
  wire logic [31:0] prdata;
  wire logic [31:0] alignedWord;
  wire logic [31:0] configData;
  wire logic        pready, pslverr, initPinIn, initPinOut, initPinOe, configClock;
  wire logic        wordSyncFlag, memClearActive, alignedWordValid;
  logic [31:0] expQ[$];
  logic [31:0] lastW;
  int          nErrors = 0;
  int          checksDone = 0;

  always #10 core_clk = ~core_clk;

  cife_top #(.CLEAR_CYCLES(CLR)) cife_top_inst (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .programN(programN), .initPinIn(initPinIn),
    .initPinOut(initPinOut), .initPinOe(initPinOe), .modeSelPins(modeSelPins),
    .flashSelectPins(flashSelectPins), .configClock(configClock),
    .configData(configData), .cfgDone(cfgDone), .cfgCrcError(cfgCrcError),
    .readbackCrcError(readbackCrcError), .abortActive(abortActive),
    .wordSyncFlag(wordSyncFlag), .memClearActive(memClearActive),
    .alignedWord(alignedWord), .alignedWordValid(alignedWordValid));
  cife_cfg_src cife_cfg_src_inst (
    .initPinOut(initPinOut), .initPinOe(initPinOe), .holdLow(holdLow),
    .initPinIn(initPinIn), .configClock(configClock), .configData(configData));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrapUp();
    if (nErrors == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) nErrors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction
  // one stream word: serial msb first, parallel bit-reversed per byte
  task automatic sendWord(input logic [31:0] w, input int wc);
    logic [31:0] r;
    r = {rev8(w[31:24]), rev8(w[23:16]), rev8(w[15:8]), rev8(w[7:0])};
    if (wc == 0) for (int i = 31; i >= 0; i--) cife_cfg_src_inst.send({31'h0, w[i]});
    else if (wc == 1) for (int i = 3; i >= 0; i--) cife_cfg_src_inst.send({24'h0, r[i*8+:8]});
    else if (wc == 2) for (int i = 1; i >= 0; i--) cife_cfg_src_inst.send({16'h0, r[i*16+:16]});
    else cife_cfg_src_inst.send(r);
  endtask
  // junk, width pattern, sync word, two random words
  task automatic stream(input int wc, input logic live);
    logic [31:0] w;
    cife_cfg_src_inst.send(32'h5a);
    if (wc == 0) sendWord(32'hbb11bb11, 0);
    else begin
      cife_cfg_src_inst.send({24'h0, `CIFE_WD_MARK});
      cife_cfg_src_inst.send(wc == 1 ? {24'h0, `CIFE_WD_X8} :
        wc == 2 ? {16'h0, `CIFE_WD_X16} : `CIFE_WD_X32);
    end
    sendWord(`CIFE_SYNC_WORD, wc);
    repeat (2) begin
      w = $urandom();
      if (live) expQ.push_back(w);
      if (live) lastW = w;
      sendWord(w, wc);
    end
    cife_cfg_src_inst.park();
  endtask
  // one-cycle error pulse: readback error if rb, configuration error otherwise
  task automatic pulse(input logic rb);
    @(posedge core_clk);
    if (rb) readbackCrcError <= 1'b1;
    else cfgCrcError <= 1'b1;
    @(posedge core_clk);
    readbackCrcError <= 1'b0;
    cfgCrcError <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  // reference queue: each aligned word must be the next one sent
  always @(posedge core_clk) begin
    if (alignedWordValid === 1'b1) begin
      if (expQ.size() > 0) chk(alignedWord, expQ.pop_front());
      else chk(32'h1, 32'h0);
    end
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [2:0]  flSel;
    int          k;
    void'($urandom(32'hecd6));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, `CIFE_REG_CTRL, 32'h0, rd, er);
    chk(rd, {28'h0, `CIFE_CTRL_RESET});
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    for (int r = 0; r < 4; r++) begin
      flSel = 3'($urandom());
      programN <= 1'b0;
      holdLow <= 1'b1;
      modeSelPins <= MODES[r];
      flashSelectPins <= flSel;
      repeat (3) @(posedge core_clk);
      programN <= 1'b1;
      k = 0;
      while (initPinOe !== 1'b0 && k < 400) begin
        @(posedge core_clk);
        k++;
      end
      chk({31'h0, k >= 2 * CLR && k < 400}, 32'h1);
      abortActive <= 1'b1;
      stream(WCS[r], 1'b0);
      chk({31'h0, wordSyncFlag}, 32'h0);
      @(posedge core_clk);
      holdLow <= 1'b0;
      abortActive <= 1'b0;
      repeat (10) @(posedge core_clk);
      flashSelectPins <= ~flSel;
      apb(1'b0, `CIFE_REG_STATUS, 32'h0, rd, er);
      chk({31'h0, rd[`CIFE_ST_INIT_DONE]}, 32'h1);
      chk({29'h0, rd[`CIFE_ST_FLSEL_LSB+:3]}, {29'h0, flSel});
      chk({31'h0, rd[`CIFE_ST_SYNCED_SEEN]}, 32'h0);
      holdLow <= 1'b1;
      repeat (8) @(posedge core_clk);
      holdLow <= 1'b0;
      stream(WCS[r], 1'b1);
      repeat (12) @(posedge core_clk);
      chk(32'(expQ.size()), 32'h0);
      apb(1'b0, `CIFE_REG_STATUS, 32'h0, rd, er);
      chk({30'h0, rd[`CIFE_ST_WIDTH_LSB+:2]}, 32'(WCS[r]));
      chk({31'h0, rd[`CIFE_ST_SYNCED_SEEN]}, 32'h1);
      apb(1'b0, `CIFE_REG_WORD, 32'h0, rd, er);
      chk(rd, lastW);
      abortActive <= 1'b1;
      modeSelPins <= ~MODES[r];
      repeat (8) @(posedge core_clk);
      chk({31'h0, wordSyncFlag}, 32'h1);
      abortActive <= 1'b0;
      apb(1'b0, `CIFE_REG_STATUS, 32'h0, rd, er);
      chk({29'h0, rd[`CIFE_ST_MODE_LSB+:3]}, {29'h0, ~MODES[r]});
      if (r == 0) begin
        pulse(1'b1);
        chk({31'h0, initPinOe}, 32'h0);
        pulse(1'b0);
        chk({31'h0, initPinOe}, 32'h1);
      end else if (r == 1) begin
        apb(1'b1, `CIFE_REG_CTRL, 32'h1 << `CIFE_CT_RB_CRC_EN, rd, er);
        pulse(1'b1);
        chk({31'h0, initPinOe}, 32'h1);
      end else if (r == 2) begin
        apb(1'b1, `CIFE_REG_CTRL, (32'h1 << `CIFE_CT_IPORT_EN) | (32'h2 << `CIFE_CT_IPORT_W_LSB),
            rd, er);
        cfgDone <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(1'b0, `CIFE_REG_STATUS, 32'h0, rd, er);
        chk({30'h0, rd[`CIFE_ST_WIDTH_LSB+:2]}, 32'h2);
        cfgDone <= 1'b0;
      end
      apb(1'b1, `CIFE_REG_CTRL, 32'h0, rd, er);
    end
    wrapUp();
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #500000;
    nErrors++;
    wrapUp();
  end
endmodule
`default_nettype wire
